//--- design/shared_pin_function_select.sv
// shared pin multiplexer with its axi4-lite configuration registers
//
// Behaviour
// [RQ1] after reset both clock pins carry the divided cpu clocks
// [RQ2] a set gpio enable bit hands its pin to gpio logic
// [RQ3] gpio direction zero makes an input, one a driven output
// [RQ4] vcxo pin carries control output unless gpio bit 8 enabled
// [RQ5] after reset the eight shared video/audio pins have no function
// [RQ6] video select connects pins as video port 1 upper data
// [RQ7] audio select connects pins as audio lanes 7..0, video off
// [RQ8] mac strap sampled at reset; one gives host pins to mii
// [RQ9] external drivers on address pins 18..0 hold reset level or float
// [RQ10] strap zero keeps mac powered down and host data on pins
// [RQ11] select writes need key unlock first; any config write relocks
// [RQ12] both selects set still give the shared pins to one function
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module shared_pin_function_select
    import pinmux_pkg::*;
(
    input  wire logic                         clock,
    input  wire logic                         resetn,
    // axi4-lite slave
    input  wire logic [7:0]                   awaddr,
    input  wire logic                         awvalid,
    output var  logic                         awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output var  logic                         wready,
    output var  logic [1:0]                   bresp,
    output var  logic                         bvalid,
    input  wire logic                         bready,
    input  wire logic [7:0]                   araddr,
    input  wire logic                         arvalid,
    output var  logic                         arready,
    output var  logic [31:0]                  rdata,
    output var  logic [1:0]                   rresp,
    output var  logic                         rvalid,
    input  wire logic                         rready,
    // clock output pins
    input  wire logic                         cpu_div4_clock_out,
    input  wire logic                         cpu_div6_clock_out,
    output var  logic [1:0]                   clock_pin_out,
    output var  logic [1:0]                   clock_pin_oe,
    input  wire logic [1:0]                   clock_pin_in,
    // vcxo control pin
    input  wire logic                         vcxo_control_out,
    output var  logic                         vcxo_pin_out,
    output var  logic                         vcxo_pin_oe,
    input  wire logic                         vcxo_pin_in,
    // shared video/audio pins
    input  wire logic [SHARED_LANES-1:0]      video_port1_data_out,
    input  wire logic [SHARED_LANES-1:0]      video_port1_data_oe,
    output var  logic [SHARED_LANES-1:0]      video_port1_data_in,
    input  wire logic [SHARED_LANES-1:0]      audio_serial_data0_out,
    input  wire logic [SHARED_LANES-1:0]      audio_serial_data0_oe,
    output var  logic [SHARED_LANES-1:0]      audio_serial_data0_in,
    output var  logic [SHARED_LANES-1:0]      shared_pin_out,
    output var  logic [SHARED_LANES-1:0]      shared_pin_oe,
    input  wire logic [SHARED_LANES-1:0]      shared_pin_in,
    // host port upper data pins and mii
    input  wire logic [HOST_SHARED_WIDTH-1:0] host_port_data_out,
    input  wire logic [HOST_SHARED_WIDTH-1:0] host_port_data_oe,
    output var  logic [HOST_SHARED_WIDTH-1:0] host_port_data_in,
    output var  logic [HOST_SHARED_WIDTH-1:0] host_pin_out,
    output var  logic [HOST_SHARED_WIDTH-1:0] host_pin_oe,
    input  wire logic [HOST_SHARED_WIDTH-1:0] host_pin_in,
    output var  mii_rx_t                      mii_rx,
    output var  mii_tx_in_t                   mii_tx_in,
    input  wire mii_tx_out_t                  mii_tx_out,
    // strap and mac state
    input  wire logic                         ethernet_mac_strap,
    output var  logic                         ethernet_mac_enable,
    output var  logic                         ethernet_mac_power_down
);
    // bus state
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    // configuration state
    logic [15:0] gpio_pin_enable_q, gpio_pin_enable_d;
    logic [15:0] gpio_pin_direction_q, gpio_pin_direction_d;
    logic [15:0] gpio_out_q, gpio_out_d;
    periph_cfg_t cfg_q, cfg_d;
    logic        locked_q, locked_d;
    logic [1:0]  settle_q, settle_d;
    logic        mac_q, mac_d;
    // synchronised pin inputs, write strobe and shared pin owners
    logic [3:0]  pin_sync_out;
    logic [15:0] gpio_in;
    logic        strap_sync;
    logic        do_write;
    logic        video_owns, audio_owns;

    pin_sync #(.WIDTH(4)) u_sync (
        .clock    (clock),
        .resetn   (resetn),
        .async_in ({ethernet_mac_strap, vcxo_pin_in, clock_pin_in}),
        .sync_out (pin_sync_out)
    );

    assign strap_sync = pin_sync_out[3];

    // gpio input view: only the bits that own a pin here
    always_comb begin
        gpio_in                = 16'h0000;
        gpio_in[GPIO_CLK4_BIT] = pin_sync_out[0];
        gpio_in[GPIO_CLK6_BIT] = pin_sync_out[1];
        gpio_in[GPIO_VCXO_BIT] = pin_sync_out[2];
    end

    assign awready  = !aw_have_q;
    assign wready   = !w_have_q;
    assign arready  = !rvalid_q;
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;
    assign rvalid   = rvalid_q;
    assign rresp    = rresp_q;
    assign rdata    = rdata_q;
    // a write is done once address and data are both held and no response is pending
    assign do_write = aw_have_q && w_have_q && !bvalid_q;

    // next state of bus channels and registers
    always_comb begin
        aw_have_d            = aw_have_q;
        w_have_d             = w_have_q;
        awaddr_d             = awaddr_q;
        wdata_d              = wdata_q;
        wstrb_d              = wstrb_q;
        bvalid_d             = bvalid_q;
        bresp_d              = bresp_q;
        rvalid_d             = rvalid_q;
        rresp_d              = rresp_q;
        rdata_d              = rdata_q;
        gpio_pin_enable_d    = gpio_pin_enable_q;
        gpio_pin_direction_d = gpio_pin_direction_q;
        gpio_out_d           = gpio_out_q;
        cfg_d                = cfg_q;
        locked_d             = locked_q;
        if (awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            awaddr_d  = awaddr;
        end
        if (wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wdata_d  = wdata;
            wstrb_d  = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case ({awaddr_q[7:2], 2'h0})
                GPIO_ENABLE_OFFSET: begin
                    if (wstrb_q[0]) gpio_pin_enable_d[7:0] = wdata_q[7:0];
                    if (wstrb_q[1]) gpio_pin_enable_d[15:8] = wdata_q[15:8];
                end
                GPIO_DIRECTION_OFFSET: begin
                    if (wstrb_q[0]) gpio_pin_direction_d[7:0] = wdata_q[7:0];
                    if (wstrb_q[1]) gpio_pin_direction_d[15:8] = wdata_q[15:8];
                end
                GPIO_OUTPUT_OFFSET: begin
                    if (wstrb_q[0]) gpio_out_d[7:0] = wdata_q[7:0];
                    if (wstrb_q[1]) gpio_out_d[15:8] = wdata_q[15:8];
                end
                PERIPH_CONFIG_OFFSET: begin
                    // locked writes are dropped silently, but still relock
                    if (!locked_q && wstrb_q[0]) begin // RQ11
                        cfg_d.video_port1_select = wdata_q[VIDEO_SEL_BIT];
                        cfg_d.audio_port0_select = wdata_q[AUDIO_SEL_BIT];
                    end
                    locked_d = 1'b1; // RQ11
                end
                CONFIG_LOCK_OFFSET: begin
                    if (wstrb_q == 4'hF && wdata_q == UNLOCK_KEY) begin
                        locked_d = 1'b0; // RQ11
                    end
                end
                GPIO_INPUT_OFFSET, DEVICE_STATUS_OFFSET: ;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h00000000;
            case ({araddr[7:2], 2'h0})
                GPIO_ENABLE_OFFSET:    rdata_d[15:0] = gpio_pin_enable_q;
                GPIO_DIRECTION_OFFSET: rdata_d[15:0] = gpio_pin_direction_q;
                GPIO_OUTPUT_OFFSET:    rdata_d[15:0] = gpio_out_q;
                GPIO_INPUT_OFFSET:     rdata_d[15:0] = gpio_in;
                PERIPH_CONFIG_OFFSET: begin
                    rdata_d[VIDEO_SEL_BIT] = cfg_q.video_port1_select;
                    rdata_d[AUDIO_SEL_BIT] = cfg_q.audio_port0_select;
                end
                CONFIG_LOCK_OFFSET:    rdata_d[LOCK_STAT_BIT] = locked_q;
                DEVICE_STATUS_OFFSET:  rdata_d[MAC_STAT_BIT] = mac_q;
                default:               rresp_d = RESP_SLVERR;
            endcase
        end
    end

    // strap capture once the synchroniser has filled
    always_comb begin
        settle_d = settle_q;
        mac_d    = mac_q;
        if (settle_q != STRAP_SETTLE_CYCLES) begin
            settle_d = settle_q + 2'h1;
            if (settle_d == STRAP_SETTLE_CYCLES) begin
                mac_d = strap_sync; // RQ8
            end
        end
    end

    // register stage only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_have_q            <= 1'b0;
            w_have_q             <= 1'b0;
            awaddr_q             <= 8'h00;
            wdata_q              <= 32'h00000000;
            wstrb_q              <= 4'h0;
            bvalid_q             <= 1'b0;
            bresp_q              <= RESP_OKAY;
            rvalid_q             <= 1'b0;
            rresp_q              <= RESP_OKAY;
            rdata_q              <= 32'h00000000;
            gpio_pin_enable_q    <= GPIO_ENABLE_RESET; // RQ1
            gpio_pin_direction_q <= GPIO_DIRECTION_RESET;
            gpio_out_q           <= GPIO_OUTPUT_RESET;
            cfg_q                <= PERIPH_CONFIG_RESET; // RQ5
            locked_q             <= LOCK_RESET;
            settle_q             <= 2'h0;
            mac_q                <= 1'b0;
        end else begin
            aw_have_q            <= aw_have_d;
            w_have_q             <= w_have_d;
            awaddr_q             <= awaddr_d;
            wdata_q              <= wdata_d;
            wstrb_q              <= wstrb_d;
            bvalid_q             <= bvalid_d;
            bresp_q              <= bresp_d;
            rvalid_q             <= rvalid_d;
            rresp_q              <= rresp_d;
            rdata_q              <= rdata_d;
            gpio_pin_enable_q    <= gpio_pin_enable_d;
            gpio_pin_direction_q <= gpio_pin_direction_d;
            gpio_out_q           <= gpio_out_d;
            cfg_q                <= cfg_d;
            locked_q             <= locked_d;
            settle_q             <= settle_d;
            mac_q                <= mac_d;
        end
    end

    assign ethernet_mac_enable     = mac_q;
    assign ethernet_mac_power_down = !mac_q; // RQ10

    // clock pins: divided clocks unless gpio takes over
    always_comb begin
        clock_pin_out[0] = cpu_div4_clock_out;
        clock_pin_out[1] = cpu_div6_clock_out;
        clock_pin_oe     = 2'h3; // RQ1
        if (gpio_pin_enable_q[GPIO_CLK4_BIT]) begin // RQ2
            clock_pin_out[0] = gpio_out_q[GPIO_CLK4_BIT];
            clock_pin_oe[0]  = gpio_pin_direction_q[GPIO_CLK4_BIT]; // RQ3
        end
        if (gpio_pin_enable_q[GPIO_CLK6_BIT]) begin // RQ2
            clock_pin_out[1] = gpio_out_q[GPIO_CLK6_BIT];
            clock_pin_oe[1]  = gpio_pin_direction_q[GPIO_CLK6_BIT]; // RQ3
        end
    end

    // vcxo pin
    always_comb begin
        vcxo_pin_out = vcxo_control_out;
        vcxo_pin_oe  = 1'b1;
        if (gpio_pin_enable_q[GPIO_VCXO_BIT]) begin // RQ4
            vcxo_pin_out = gpio_out_q[GPIO_VCXO_BIT];
            vcxo_pin_oe  = gpio_pin_direction_q[GPIO_VCXO_BIT];
        end
    end

    // video wins a double select so the pins never see two drivers
    assign video_owns = cfg_q.video_port1_select; // RQ12
    assign audio_owns = cfg_q.audio_port0_select && !video_owns; // RQ12

    always_comb begin
        shared_pin_out        = '0; // RQ5
        shared_pin_oe         = '0;
        video_port1_data_in   = '0;
        audio_serial_data0_in = '0;
        if (video_owns) begin // RQ6
            shared_pin_out      = video_port1_data_out;
            shared_pin_oe       = video_port1_data_oe;
            video_port1_data_in = shared_pin_in;
        end else if (audio_owns) begin // RQ7
            shared_pin_out        = audio_serial_data0_out;
            shared_pin_oe         = audio_serial_data0_oe;
            audio_serial_data0_in = shared_pin_in;
        end
    end

    // host pins: bit 7 always stays with the host port
    always_comb begin
        host_pin_out      = host_port_data_out; // RQ10
        host_pin_oe       = host_port_data_oe;
        host_port_data_in = host_pin_in;
        mii_rx            = '0;
        mii_tx_in         = '0;
        if (mac_q) begin // RQ8
            mii_rx            = host_pin_in[15:8];
            mii_tx_in         = host_pin_in[6:5];
            host_pin_oe[15:8] = 8'h00;
            host_pin_oe[6:5]  = 2'h0;
            host_pin_out[4:0] = mii_tx_out;
            host_pin_oe[4:0]  = 5'h1F;
            host_port_data_in[15:8] = 8'h00;
            host_port_data_in[6:0]  = 7'h00;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_clk_default: assert property (!gpio_pin_enable_q[GPIO_CLK4_BIT]
        |-> clock_pin_oe[0] && clock_pin_out[0] == cpu_div4_clock_out)
        else $error("clock pin lost its divided clock"); // RQ1
    a_gpio_takeover: assert property (gpio_pin_enable_q[GPIO_CLK6_BIT]
        |-> clock_pin_out[1] == gpio_out_q[GPIO_CLK6_BIT])
        else $error("gpio enable did not take the pin"); // RQ2
    a_gpio_direction: assert property (gpio_pin_enable_q[GPIO_CLK4_BIT]
        |-> clock_pin_oe[0] == gpio_pin_direction_q[GPIO_CLK4_BIT])
        else $error("gpio direction not applied"); // RQ3
    a_vcxo_select: assert property (vcxo_pin_out == (gpio_pin_enable_q[8]
        ? gpio_out_q[8] : vcxo_control_out))
        else $error("vcxo pin routed wrongly"); // RQ4
    a_shared_idle: assert property (!cfg_q.video_port1_select
        && !cfg_q.audio_port0_select |-> shared_pin_oe == '0)
        else $error("idle shared pins driven"); // RQ5
    a_video_route: assert property (cfg_q.video_port1_select
        |-> shared_pin_oe == video_port1_data_oe
            && audio_serial_data0_in == '0)
        else $error("video select not routed"); // RQ6
    a_audio_route: assert property (audio_owns
        |-> shared_pin_out == audio_serial_data0_out
            && video_port1_data_in == '0)
        else $error("audio select not routed"); // RQ7
    a_single_owner: assert property (!(video_owns && audio_owns))
        else $error("shared pins given to two owners"); // RQ12
    a_strap_stable: assert property (settle_q == STRAP_SETTLE_CYCLES
        |=> $stable(mac_q))
        else $error("mac strap changed after capture"); // RQ8
    a_mac_off: assert property (!mac_q |-> host_pin_oe == host_port_data_oe
        && ethernet_mac_power_down)
        else $error("host pins taken while mac off"); // RQ10
    a_unlock_key: assert property (do_write
        && awaddr_q[7:2] == CONFIG_LOCK_OFFSET[7:2]
        && wdata_q == UNLOCK_KEY && wstrb_q == 4'hF |=> !locked_q)
        else $error("key did not unlock"); // RQ11
    a_relock: assert property (do_write
        && awaddr_q[7:2] == PERIPH_CONFIG_OFFSET[7:2] |=> locked_q)
        else $error("config write did not relock"); // RQ11
    a_locked_hold: assert property (do_write && locked_q
        && awaddr_q[7:2] == PERIPH_CONFIG_OFFSET[7:2] |=> $stable(cfg_q))
        else $error("locked config register changed"); // RQ11

    c_video: cover property (video_owns ##1 video_port1_data_oe != '0);
    c_audio: cover property (audio_owns);
    c_mac: cover property (mac_q && mii_tx_out.tx_enable);
    c_unlock: cover property (!locked_q ##[1:20] locked_q);
endmodule : shared_pin_function_select
`default_nettype wire

//--- design/pinmux_pkg.sv
// constants and carrier types for the shared pin function selector
package pinmux_pkg;
    // register byte offsets
    localparam logic [7:0]  GPIO_ENABLE_OFFSET    = 8'h00;
    localparam logic [7:0]  GPIO_DIRECTION_OFFSET = 8'h04;
    localparam logic [7:0]  GPIO_OUTPUT_OFFSET    = 8'h08;
    localparam logic [7:0]  GPIO_INPUT_OFFSET     = 8'h0C;
    localparam logic [7:0]  PERIPH_CONFIG_OFFSET  = 8'h10;
    localparam logic [7:0]  CONFIG_LOCK_OFFSET    = 8'h14;
    localparam logic [7:0]  DEVICE_STATUS_OFFSET  = 8'h18;
    // unlock key for the peripheral configuration register
    localparam logic [31:0] UNLOCK_KEY            = 32'h10C0010C;
    // widths and field positions
    localparam int          GPIO_WIDTH            = 16;
    localparam int          GPIO_CLK4_BIT         = 1;
    localparam int          GPIO_CLK6_BIT         = 2;
    localparam int          GPIO_VCXO_BIT         = 8;
    localparam int          SHARED_LANES          = 8;
    localparam int          HOST_SHARED_WIDTH     = 16;
    localparam int          AUDIO_SEL_BIT         = 0;
    localparam int          VIDEO_SEL_BIT         = 1;
    localparam int          LOCK_STAT_BIT         = 0;
    localparam int          MAC_STAT_BIT          = 0;
    // reset values
    localparam logic [15:0] GPIO_ENABLE_RESET     = 16'h0000;
    localparam logic [15:0] GPIO_DIRECTION_RESET  = 16'h0000;
    localparam logic [15:0] GPIO_OUTPUT_RESET     = 16'h0000;
    localparam logic        LOCK_RESET            = 1'b1;
    // cycles until the synchronised strap is trusted
    localparam logic [1:0]  STRAP_SETTLE_CYCLES   = 2'h3;
    // bus responses
    localparam logic [1:0]  RESP_OKAY             = 2'h0;
    localparam logic [1:0]  RESP_SLVERR           = 2'h2;

    typedef struct packed {
        logic video_port1_select;
        logic audio_port0_select;
    } periph_cfg_t;

    localparam periph_cfg_t PERIPH_CONFIG_RESET = '{1'b0, 1'b0};

    // media independent interface, receive side: host bits 15..8
    typedef struct packed {
        logic       rx_clock;
        logic       carrier_sense;
        logic       rx_error;
        logic       rx_valid;
        logic [3:0] rx_data;
    } mii_rx_t;

    // transmit side inputs: host bits 6..5
    typedef struct packed {
        logic tx_clock;
        logic collision;
    } mii_tx_in_t;

    // transmit side outputs: host bits 4..0
    typedef struct packed {
        logic       tx_enable;
        logic [3:0] tx_data;
    } mii_tx_out_t;
endpackage : pinmux_pkg

//--- design/pin_sync.sv
// two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

//--- verification/pad_side_model.sv
// pad and peripheral side model: divided cpu clocks and pad levels
`timescale 1ns/10ps
`default_nettype none
module pad_side_model #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    input  wire logic [W-1:0] ext_level,
    output var  logic [W-1:0] pad_in,
    output var  logic         cpu_div4_clock_out,
    output var  logic         cpu_div6_clock_out
);
    logic [1:0] cnt4_q;
    logic [2:0] cnt6_q;

    // outside drivers only act on pads the device has released
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
    assign cpu_div4_clock_out = cnt4_q[1];
    assign cpu_div6_clock_out = (cnt6_q > 3'h2);

    // free running dividers, so the clock pins toggle during checks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt4_q <= 2'h0;
            cnt6_q <= 3'h0;
        end else begin
            cnt4_q <= cnt4_q + 2'h1;
            cnt6_q <= (cnt6_q == 3'h5) ? 3'h0 : cnt6_q + 3'h1;
        end
    end
endmodule : pad_side_model
`default_nettype wire

//--- verification/shared_pin_function_select_tb_top.sv
// self-checking bench for the shared pin function selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module shared_pin_function_select_tb_top
    import pinmux_pkg::*;
;
    int seed = 32'hA5F2;
    int n_fail = 0;
    int checks_done = 0;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hold = 1'b0;
    logic ethernet_mac_strap = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, vcxo_control_out = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, cfg = '0, d, v;
    logic [3:0] wstrb = '0;
    logic [7:0] video_port1_data_out = '0, video_port1_data_oe = '0;
    logic [7:0] audio_serial_data0_out = '0, audio_serial_data0_oe = '0;
    logic [15:0] host_port_data_out = '0, host_port_data_oe = '0;
    logic [26:0] ext = '0;
    mii_tx_out_t mii_tx_out = '0;
    logic awready, wready, bvalid, arready, rvalid, vcxo_pin_out;
    logic vcxo_pin_oe, ethernet_mac_enable, ethernet_mac_power_down;
    logic [1:0] bresp, rresp, clock_pin_out, clock_pin_oe;
    logic [31:0] rdata;
    logic [7:0] video_port1_data_in, audio_serial_data0_in;
    logic [7:0] shared_pin_out, shared_pin_oe;
    logic [15:0] host_port_data_in, host_pin_out, host_pin_oe;
    mii_rx_t mii_rx;
    mii_tx_in_t mii_tx_in;
    wire [1:0] clock_pin_in;
    wire vcxo_pin_in, cpu_div4_clock_out, cpu_div6_clock_out;
    wire [7:0] shared_pin_in;
    wire [15:0] host_pin_in;
    wire [26:0] pad_in;

    assign {clock_pin_in, vcxo_pin_in, shared_pin_in, host_pin_in} = pad_in;

    shared_pin_function_select shared_pin_function_select_i (.*);

    pad_side_model #(.W(27)) pad_side_model_i (
        .clock              (clock),
        .resetn             (resetn),
        .pad_out            ({clock_pin_out, vcxo_pin_out, shared_pin_out,
                              host_pin_out}),
        .pad_oe             ({clock_pin_oe, vcxo_pin_oe, shared_pin_oe,
                              host_pin_oe}),
        .ext_level          (ext),
        .pad_in             (pad_in),
        .cpu_div4_clock_out (cpu_div4_clock_out),
        .cpu_div6_clock_out (cpu_div6_clock_out)
    );

    // 50 ns clock
    initial begin
        forever #25 clock = ~clock;
    end

    // peripheral traffic changes every cycle, outside pad levels every cycle while hold is low
    always @(posedge clock) begin
        {video_port1_data_out, video_port1_data_oe, audio_serial_data0_out,
         audio_serial_data0_oe, host_port_data_out, host_port_data_oe}
            <= {$random(seed), $random(seed)};
        {vcxo_control_out, mii_tx_out} <= 6'($random(seed));
        if (!hold) ext <= 27'($random(seed));
    end

    // write: address and data offered together, each dropped when taken
    task wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge clock);
        awaddr <= a;
        wdata <= x;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        `CHK(bresp, RESP_OKAY)
    endtask : wr

    // read and compare data and response
    task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        `CHK({rdata, rresp}, {x, r})
    endtask : rd

    task stop_test;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // hang guard, well past the run's length
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(negedge clock);
        `CHK({clock_pin_oe, clock_pin_out}, {2'h3, cpu_div6_clock_out, cpu_div4_clock_out})
        `CHK({vcxo_pin_oe, vcxo_pin_out}, {1'b1, vcxo_control_out})
        `CHK(shared_pin_oe, 8'h00)
        `CHK({ethernet_mac_enable, ethernet_mac_power_down}, 2'h1)
        `CHK({host_pin_out, host_pin_oe}, {host_port_data_out, host_port_data_oe})
        rd(DEVICE_STATUS_OFFSET, 32'h0, RESP_OKAY);
        rd(8'h1C, 32'h0, RESP_SLVERR);
        for (int s = 1; s < 4; s++) begin
            wr(CONFIG_LOCK_OFFSET, ~UNLOCK_KEY);
            wr(PERIPH_CONFIG_OFFSET, s);
            rd(PERIPH_CONFIG_OFFSET, cfg, RESP_OKAY);
            wr(CONFIG_LOCK_OFFSET, UNLOCK_KEY);
            rd(CONFIG_LOCK_OFFSET, 32'h0, RESP_OKAY);
            wr(PERIPH_CONFIG_OFFSET, s);
            cfg = s;
            rd(CONFIG_LOCK_OFFSET, 32'h1, RESP_OKAY);
            @(negedge clock);
            `CHK(shared_pin_oe, s[1] ? video_port1_data_oe : audio_serial_data0_oe)
            `CHK(shared_pin_out & shared_pin_oe, s[1] ? video_port1_data_out & video_port1_data_oe : audio_serial_data0_out & audio_serial_data0_oe)
            `CHK({video_port1_data_in, audio_serial_data0_in}, s[1] ? {shared_pin_in, 8'h0} : {8'h0, shared_pin_in})
        end
        // pads held so synced gpio inputs settle
        hold <= 1'b1;
        wr(GPIO_ENABLE_OFFSET, 32'h0106);
        for (int i = 0; i < 8; i++) begin
            d = {23'h0, i[2], 5'h0, i[1:0], 1'b0};
            v = 32'($random(seed));
            wr(GPIO_DIRECTION_OFFSET, d);
            wr(GPIO_OUTPUT_OFFSET, v);
            @(negedge clock);
            `CHK({vcxo_pin_oe, clock_pin_oe}, {d[8], d[2:1]})
            `CHK(clock_pin_out & clock_pin_oe, v[2:1] & d[2:1])
            `CHK(vcxo_pin_out & vcxo_pin_oe, v[8] & d[8])
            repeat (3) @(posedge clock);
            rd(GPIO_INPUT_OFFSET, (d & v | ~d & {ext[24], 5'h0, ext[26:25], 1'b0}) & 32'h0106, RESP_OKAY);
        end
        // second reset in mid-run with the strap high
        hold <= 1'b0;
        resetn <= 1'b0;
        ethernet_mac_strap <= 1'b1;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(DEVICE_STATUS_OFFSET, 32'h1, RESP_OKAY);
        repeat (20) begin
            @(negedge clock);
            `CHK(clock_pin_oe, 2'h3)
            `CHK({ethernet_mac_enable, ethernet_mac_power_down}, 2'h2)
            `CHK(host_pin_out[4:0], mii_tx_out)
            `CHK({mii_rx, mii_tx_in}, {host_pin_in[15:8], host_pin_in[6:5]})
            `CHK({host_pin_oe, host_port_data_in}, {8'h0, host_port_data_oe[7], 7'h1F, 8'h0, host_pin_in[7], 7'h0})
        end
        stop_test();
    end
endmodule : shared_pin_function_select_tb_top
`default_nettype wire
